// ===== core/sdadc_ctrl.sv
// Converter control, result and flag logic with its register port.
`timescale 1ns/1ps
module sdadc_ctrl
	import sdadc_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic [SDADC_ADDR_W-1:0] reg_addr,
	input  wire logic [SDADC_DATA_W-1:0] reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [SDADC_DATA_W-1:0] reg_rdata,
	input  wire sdadc_fe_res_t           fe_res,
	output sdadc_fe_ctl_t                fe_ctl,
	output logic                         irq
);

	logic                   hold_reg;
	logic                   done_reg;
	logic                   done_next;
	logic                   restart_reg;
	logic                   power_reg;
	logic                   running_reg;
	logic [SDADC_DIV_W-1:0] div_reg;
	logic [1:0]             ref_code_reg;
	logic                   gie_reg;
	logic                   cie_reg;
	logic                   ireq_reg;
	logic                   ireq_next;
	logic [SDADC_RES_W-1:0] result_reg;
	logic [SDADC_RES_W-1:0] result_next;
	logic                   wr_ctrl1;
	logic                   wr_clkset;
	logic                   wr_gainref;
	logic                   wr_irq;
	logic                   start_pulse;
	logic                   accept;
	logic                   mclk_tick;
	sdadc_ref_t             ref_sel;

	function automatic logic [SDADC_RES_W-1:0] sdadc_clamp(
		input logic signed [SDADC_RAW_W-1:0] raw
	);
		logic signed [SDADC_RAW_W-1:0] hi;
		logic signed [SDADC_RAW_W-1:0] lo;
		hi = {{(SDADC_RAW_W-SDADC_RES_W){1'b0}}, SDADC_RES_MAX};
		lo = {{(SDADC_RAW_W-SDADC_RES_W){1'b1}}, SDADC_RES_MIN};
		if (raw > hi) begin
			sdadc_clamp = SDADC_RES_MAX;
		end else if (raw < lo) begin
			sdadc_clamp = SDADC_RES_MIN;
		end else begin
			sdadc_clamp = raw[SDADC_RES_W-1:0];
		end
	endfunction

	assign wr_ctrl1   = reg_wr && (reg_addr == SDADC_OFS_CTRL1);
	assign wr_clkset  = reg_wr && (reg_addr == SDADC_OFS_CLKSET);
	assign wr_gainref = reg_wr && (reg_addr == SDADC_OFS_GAINREF);
	assign wr_irq     = reg_wr && (reg_addr == SDADC_OFS_IRQ);

	// Conversions launch only on the release of a restart that was set.
	assign start_pulse = restart_reg && wr_ctrl1 && !reg_wdata[SDADC_BIT_RESTART];

	// A result counts only while powered, started, out of restart and not held.
	assign accept = fe_res.valid && running_reg && power_reg && !restart_reg
		&& !hold_reg;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hold_reg    <= SDADC_CTRL1_RST[SDADC_BIT_HOLD];
			restart_reg <= SDADC_CTRL1_RST[SDADC_BIT_RESTART];
			power_reg   <= SDADC_CTRL1_RST[SDADC_BIT_POWER];
		end else if (wr_ctrl1) begin
			hold_reg    <= reg_wdata[SDADC_BIT_HOLD];
			restart_reg <= reg_wdata[SDADC_BIT_RESTART];
			power_reg   <= reg_wdata[SDADC_BIT_POWER];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			running_reg <= 1'b0;
		end else if (restart_reg || !power_reg) begin
			running_reg <= start_pulse && power_reg;
		end
	end

	// A finished conversion beats a clearing write in the same cycle.
	always_comb begin
		done_next = done_reg;
		if (wr_ctrl1) begin
			done_next = reg_wdata[SDADC_BIT_DONE];
		end
		if (accept) begin
			done_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			done_reg <= SDADC_CTRL1_RST[SDADC_BIT_DONE];
		end else begin
			done_reg <= done_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_reg <= SDADC_DIV_RST;
		end else if (wr_clkset) begin
			div_reg <= reg_wdata[SDADC_DIV_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ref_code_reg <= 2'h0;
		end else if (wr_gainref) begin
			ref_code_reg <= reg_wdata[SDADC_REF_LSB+1:SDADC_REF_LSB];
		end
	end

	// The unused fourth code falls back to the common-mode pair.
	always_comb begin
		unique case (ref_code_reg)
			2'b01: ref_sel = SDADC_REF_OREG;
			2'b10: ref_sel = SDADC_REF_OREG_DV;
			default: ref_sel = SDADC_REF_VCM;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			gie_reg <= 1'b0;
			cie_reg <= 1'b0;
		end else if (wr_irq) begin
			gie_reg <= reg_wdata[SDADC_BIT_GIE];
			cie_reg <= reg_wdata[SDADC_BIT_CIE];
		end
	end

	always_comb begin
		ireq_next = ireq_reg;
		if (wr_irq) begin
			ireq_next = reg_wdata[SDADC_BIT_IREQ];
		end
		if (accept) begin
			ireq_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ireq_reg <= 1'b0;
		end else begin
			ireq_reg <= ireq_next;
		end
	end

	assign irq = ireq_reg && gie_reg && cie_reg;

	// One word register updates all three bytes together; the byte reads are not latched and can span conversions.
	assign result_next = accept ? sdadc_clamp(fe_res.data) : result_reg;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			result_reg <= SDADC_RES_RST;
		end else begin
			result_reg <= result_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || !reg_rd) begin
			reg_rdata <= SDADC_RD_IDLE;
		end else begin
			unique case (reg_addr)
				SDADC_OFS_CTRL1: reg_rdata <= {2'b00, hold_reg, done_reg,
					restart_reg, power_reg, 2'b00};
				SDADC_OFS_CLKSET: reg_rdata <= {3'b000, div_reg};
				SDADC_OFS_GAINREF: reg_rdata <= {6'h00, ref_code_reg};
				SDADC_OFS_RES_LO: reg_rdata <= result_reg[7:0];
				SDADC_OFS_RES_MID: reg_rdata <= result_reg[15:8];
				SDADC_OFS_RES_HI: reg_rdata <= result_reg[23:16];
				SDADC_OFS_IRQ: reg_rdata <= {5'h00, ireq_reg, cie_reg, gie_reg};
				default: reg_rdata <= SDADC_RD_IDLE;
			endcase
		end
	end

	sdadc_clkdiv u_clkdiv (
		.clk       (clk),
		.resetn    (resetn),
		.enable    (power_reg),
		.div_code  (div_reg),
		.mclk_tick (mclk_tick)
	);

	// Power gates the whole front end, whatever its inputs carry.
	always_comb begin
		fe_ctl.power        = power_reg;
		fe_ctl.filter_reset = !running_reg;
		fe_ctl.ref_sel      = ref_sel;
		fe_ctl.mclk_tick    = mclk_tick;
	end

	chk_restart_resets: assert property (@(posedge clk) disable iff (!resetn)
		restart_reg && !start_pulse |=> fe_ctl.filter_reset)
		else $error("Filter left running during restart.");

	chk_release_starts: assert property (@(posedge clk) disable iff (!resetn)
		start_pulse && power_reg |=> !fe_ctl.filter_reset)
		else $error("Restart release did not start conversions.");

	chk_done_sets: assert property (@(posedge clk) disable iff (!resetn)
		accept |=> done_reg)
		else $error("Done flag not set after a result.");

	chk_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
		accept && gie_reg && cie_reg && !wr_irq |=> irq)
		else $error("Enabled interrupt not raised after a result.");

	chk_irq_masked: assert property (@(posedge clk) disable iff (!resetn)
		!gie_reg && !wr_irq |=> !irq)
		else $error("Interrupt delivered with global enable low.");

	chk_result_update: assert property (@(posedge clk) disable iff (!resetn)
		accept |=> result_reg == sdadc_clamp($past(fe_res.data)))
		else $error("Result word not taken whole from the new conversion.");

	chk_clamp_high: assert property (@(posedge clk) disable iff (!resetn)
		accept && fe_res.data > $signed({4'h0, SDADC_RES_MAX}) |=> result_reg == SDADC_RES_MAX)
		else $error("Over-range input not clamped to the maximum.");

	chk_sign_bit: assert property (@(posedge clk) disable iff (!resetn)
		accept && fe_res.data < 0 |=> result_reg[SDADC_RES_W-1])
		else $error("Negative input produced a positive code.");

	chk_hold_keeps: assert property (@(posedge clk) disable iff (!resetn)
		hold_reg |=> $stable(result_reg))
		else $error("Held result was overwritten.");

	chk_hold_flags: assert property (@(posedge clk) disable iff (!resetn)
		hold_reg && !wr_ctrl1 && !wr_irq |=> $stable(done_reg) && $stable(ireq_reg))
		else $error("Hold let the done flag or request change.");

	chk_done_sticky: assert property (@(posedge clk) disable iff (!resetn)
		done_reg && !wr_ctrl1 |=> done_reg)
		else $error("Done flag cleared without a software write.");

	chk_power_off: assert property (@(posedge clk) disable iff (!resetn)
		!power_reg && !wr_ctrl1 && !wr_irq |=> $stable(result_reg) && $stable(done_reg)
		&& $stable(ireq_reg) && !fe_ctl.mclk_tick)
		else $error("Unpowered converter changed state or clocked the modulator.");

	chk_read_low: assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == SDADC_OFS_RES_LO |=> reg_rdata == $past(result_reg[7:0]))
		else $error("Low result byte read back wrong.");

	chk_clamp_low: assert property (@(posedge clk) disable iff (!resetn)
		accept && fe_res.data < $signed({4'hF, SDADC_RES_MIN}) |=> result_reg == SDADC_RES_MIN)
		else $error("Under-range input not clamped to the minimum.");

	chk_read_mid: assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == SDADC_OFS_RES_MID |=> reg_rdata == $past(result_reg[15:8]))
		else $error("Middle result byte read back wrong.");

	chk_read_high: assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == SDADC_OFS_RES_HI |=> reg_rdata == $past(result_reg[23:16]))
		else $error("High result byte read back wrong.");

	chk_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!reg_rd |=> reg_rdata == SDADC_RD_IDLE)
		else $error("Read data shown outside the cycle after a read.");

	chk_ref_divided: assert property (@(posedge clk) disable iff (!resetn)
		wr_gainref && reg_wdata[SDADC_REF_LSB+1:SDADC_REF_LSB] == 2'b10
		|=> fe_ctl.ref_sel == SDADC_REF_OREG_DV)
		else $error("Divided regulator pair not selected.");

	chk_power_stops: assert property (@(posedge clk) disable iff (!resetn)
		!power_reg |=> fe_ctl.filter_reset)
		else $error("Filter left running while unpowered.");

	chk_done_clear: assert property (@(posedge clk) disable iff (!resetn)
		wr_ctrl1 && !reg_wdata[SDADC_BIT_DONE] && !accept |=> !done_reg)
		else $error("Software write did not clear the done flag.");

	cov_result: cover property (@(posedge clk) disable iff (!resetn)
		start_pulse ##[1:1000] accept);

	cov_restart: cover property (@(posedge clk) disable iff (!resetn)
		start_pulse && power_reg);

	cov_hold_discard: cover property (@(posedge clk) disable iff (!resetn)
		hold_reg && fe_res.valid && running_reg && power_reg);

	cov_irq: cover property (@(posedge clk) disable iff (!resetn)
		accept ##1 irq);

	cov_clamp_low: cover property (@(posedge clk) disable iff (!resetn)
		accept && fe_res.data < $signed({4'hF, SDADC_RES_MIN}));

endmodule

// ===== core/sdadc_pkg.sv
// Constants, register map and carrier types of the converter control block.
// How it works
// - Restart pulse resets filter, conversions start after release.
// - Finished conversion sets the done flag.
// - Finished conversion sets request; interrupt only when enabled.
// - Without hold, each result overwrites result registers.
// - With hold, keep last result, discard newer.
// - Converter clock is system clock or divided.
// - Reference select picks one of three pairs.
// - Power enable low switches converter circuitry off.
// - Result is 24-bit two's complement, MSB sign.
// - Result range 0x7FFFFF down to 0x800000.
// - Over-range and under-range clamp, never wrap.
// - Divider codes divide by two times code+1; all-ones bypasses.
// - Result bytes split low, middle, high registers.
// - Done flag cleared only by software write.
// - Hold suppresses interrupt and done flag changes.
package sdadc_pkg;

	localparam int unsigned SDADC_RES_W  = 24;
	localparam int unsigned SDADC_RAW_W  = 28;
	localparam int unsigned SDADC_ADDR_W = 8;
	localparam int unsigned SDADC_DATA_W = 8;
	localparam int unsigned SDADC_DIV_W  = 5;

	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_CTRL1   = 8'h00;
	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_CLKSET  = 8'h01;
	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_GAINREF = 8'h02;
	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_RES_LO  = 8'h03;
	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_RES_MID = 8'h04;
	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_RES_HI  = 8'h05;
	localparam logic [SDADC_ADDR_W-1:0] SDADC_OFS_IRQ     = 8'h06;

	localparam int unsigned SDADC_BIT_HOLD    = 5;
	localparam int unsigned SDADC_BIT_DONE    = 4;
	localparam int unsigned SDADC_BIT_RESTART = 3;
	localparam int unsigned SDADC_BIT_POWER   = 2;
	localparam int unsigned SDADC_BIT_GIE     = 0;
	localparam int unsigned SDADC_BIT_CIE     = 1;
	localparam int unsigned SDADC_BIT_IREQ    = 2;
	localparam int unsigned SDADC_REF_LSB     = 0;

	localparam logic [SDADC_DATA_W-1:0] SDADC_CTRL1_RST   = 8'h00;
	localparam logic [SDADC_DIV_W-1:0]  SDADC_DIV_RST     = 5'h00;
	localparam logic [SDADC_DIV_W-1:0]  SDADC_DIV_BYPASS  = 5'h1F;
	localparam logic [SDADC_RES_W-1:0]  SDADC_RES_RST     = 24'h000000;
	localparam logic [SDADC_RES_W-1:0]  SDADC_RES_MAX     = 24'h7FFFFF;
	localparam logic [SDADC_RES_W-1:0]  SDADC_RES_MIN     = 24'h800000;
	localparam logic [SDADC_DATA_W-1:0] SDADC_RD_IDLE     = 8'h00;

	typedef enum logic [1:0] {
		SDADC_REF_VCM     = 2'b00,
		SDADC_REF_OREG    = 2'b01,
		SDADC_REF_OREG_DV = 2'b10
	} sdadc_ref_t;

	typedef struct packed {
		logic       power;
		logic       filter_reset;
		sdadc_ref_t ref_sel;
		logic       mclk_tick;
	} sdadc_fe_ctl_t;

	typedef struct packed {
		logic                          valid;
		logic signed [SDADC_RAW_W-1:0] data;
	} sdadc_fe_res_t;

endpackage

// ===== core/sdadc_clkdiv.sv
// Converter master clock divider, one tick per master clock period.
`timescale 1ns/1ps
module sdadc_clkdiv
	import sdadc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   enable,
	input  wire logic [SDADC_DIV_W-1:0] div_code,
	output logic                        mclk_tick
);

	logic [SDADC_DIV_W:0] cnt_reg;
	logic [SDADC_DIV_W:0] term;
	logic                 bypass;

	// The period is 2*(code+1) system cycles, so the last count is 2*code+1.
	assign term   = {div_code, 1'b1};
	assign bypass = (div_code == SDADC_DIV_BYPASS);

	always_ff @(posedge clk) begin
		if (!resetn || !enable || bypass || cnt_reg >= term) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Stopping the tick while unpowered keeps the modulator quiet.
	always_ff @(posedge clk) begin
		if (!resetn || !enable) begin
			mclk_tick <= 1'b0;
		end else begin
			mclk_tick <= bypass || (cnt_reg >= term);
		end
	end

	chk_bypass_tick: assert property (@(posedge clk) disable iff (!resetn)
		enable && bypass |=> mclk_tick)
		else $error("Bypass code did not pass every system cycle.");

	chk_div_spacing: assert property (@(posedge clk) disable iff (!resetn)
		mclk_tick && !bypass && $stable(div_code) |=> !mclk_tick)
		else $error("Divided tick came on two cycles in a row.");

endmodule

// ===== verification/sdadc_fe_model.sv
// Behavioural front end that returns one raw filter sample per request.
`timescale 1ns/1ps
module sdadc_fe_model
	import sdadc_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire sdadc_fe_ctl_t                 fe_ctl,
	input  wire logic                          send,
	input  wire logic signed [SDADC_RAW_W-1:0] value,
	output sdadc_fe_res_t                      fe_res
);
	logic                          pend_reg;
	logic signed [SDADC_RAW_W-1:0] val_reg;
	logic                          go;
	// A sample leaves only on a master clock tick of a powered, released filter.
	assign go = pend_reg && fe_ctl.mclk_tick && fe_ctl.power && !fe_ctl.filter_reset;
	always_ff @(posedge clk) begin
		if (!resetn)
			pend_reg <= 1'b0;
		else if (send)
			pend_reg <= 1'b1;
		else if (go)
			pend_reg <= 1'b0;
		if (send)
			val_reg <= value;
	end
	// Data toggle between samples so that a stale value is never mistaken for a new one.
	always_ff @(posedge clk) begin
		if (!resetn)
			fe_res <= '0;
		else if (go)
			fe_res <= {1'b1, val_reg};
		else
			fe_res <= {1'b0, ~fe_res.data};
	end
endmodule

// ===== verification/tb_sigma_delta_adc_control.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
module tb_sigma_delta_adc_control
	import sdadc_pkg::*;
();
	logic                          clk;
	logic                          resetn;
	logic [SDADC_ADDR_W-1:0]       reg_addr;
	logic [SDADC_DATA_W-1:0]       reg_wdata;
	logic                          reg_wr;
	logic                          reg_rd;
	logic [SDADC_DATA_W-1:0]       reg_rdata;
	sdadc_fe_res_t                 fe_res;
	sdadc_fe_ctl_t                 fe_ctl;
	logic                          irq;
	logic                          send;
	logic signed [SDADC_RAW_W-1:0] value;
	logic                          rd_pend;
	logic [7:0]                    expq[$];
	logic signed [SDADC_RAW_W-1:0] tbl[8];
	logic [23:0]                   res;
	int                            fails;
	int                            checked;
	int                            cyc;
	int                            i;
	int                            n;
	int                            d;

	sdadc_ctrl uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fe_res(fe_res),
		.fe_ctl(fe_ctl), .irq(irq));
	sdadc_fe_model fe (.clk(clk), .resetn(resetn), .fe_ctl(fe_ctl), .send(send),
		.value(value), .fe_res(fe_res));

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		expq.push_back(e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// Counts edges up to the next master clock tick; bounded so a dead divider cannot hang.
	task automatic per(output int m);
		m = 0;
		do begin
			@(posedge clk);
			m++;
		end while (fe_ctl.mclk_tick !== 1'b1 && m < 100);
	endtask

	task automatic conv(input logic signed [SDADC_RAW_W-1:0] v);
		@(posedge clk);
		send <= 1'b1;
		value <= v;
		@(posedge clk);
		send <= 1'b0;
		n = 0;
		while (fe_res.valid !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
	endtask

	function automatic logic [23:0] clamp(input logic signed [SDADC_RAW_W-1:0] v);
		if (v > 28'sh07FFFFF)
			return 24'h7FFFFF;
		if (v < -28'sh0800000)
			return 24'h800000;
		return v[23:0];
	endfunction

	// Read data stand only in the cycle after the strobe, so they are sampled there.
	always @(posedge clk) begin
		if (rd_pend)
			chk({16'h0000, reg_rdata}, {16'h0000, expq.pop_front()});
		rd_pend <= reg_rd;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		send = 1'b0;
		value = '0;
		rd_pend = 1'b0;
		void'($urandom(95));
		tbl = '{28'sh07FFFFF, 28'sh0800000, -28'sh0800000, -28'sh0800001,
			28'sh7FFFFFF, 28'sh8000000, 28'sh0000000, 28'sh0000000};
		d = $urandom;
		tbl[7] = {{4{d[23]}}, d[23:0]};
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		for (i = 0; i < 8; i++)
			rd(i[7:0], 8'h00);
		chk({22'h000000, fe_ctl.power, fe_ctl.filter_reset}, 24'h000001);
		for (i = 0; i < 4; i++) begin
			wr(SDADC_OFS_GAINREF, i[7:0]);
			@(posedge clk);
			chk({22'h000000, fe_ctl.ref_sel}, (i == 3) ? 24'h000000 : 24'(i));
		end
		wr(SDADC_OFS_CTRL1, 8'h04);
		@(posedge clk);
		chk({22'h000000, fe_ctl.power, fe_ctl.filter_reset}, 24'h000003);
		for (i = 0; i < 5; i++) begin
			d = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 31 : (i == 3) ? 30 : $urandom % 31;
			wr(SDADC_OFS_CLKSET, d[7:0]);
			per(n);
			per(n);
			per(n);
			chk(n[23:0], (d == 31) ? 24'h000001 : 24'(2 * (d + 1)));
		end
		wr(SDADC_OFS_CTRL1, 8'h0C);
		@(posedge clk);
		chk({23'h000000, fe_ctl.filter_reset}, 24'h000001);
		wr(SDADC_OFS_CTRL1, 8'h04);
		@(posedge clk);
		chk({23'h000000, fe_ctl.filter_reset}, 24'h000000);
		wr(SDADC_OFS_CLKSET, 8'h01);
		wr(SDADC_OFS_IRQ, 8'h03);
		for (i = 0; i < 8; i++) begin
			conv(tbl[i]);
			res = clamp(tbl[i]);
			chk({23'h000000, irq}, 24'h000001);
			rd(SDADC_OFS_CTRL1, 8'h14);
			rd(SDADC_OFS_RES_LO, res[7:0]);
			rd(SDADC_OFS_RES_MID, res[15:8]);
			rd(SDADC_OFS_RES_HI, res[23:16]);
			rd(SDADC_OFS_CTRL1, 8'h14);
			wr(SDADC_OFS_CTRL1, 8'h04);
			wr(SDADC_OFS_IRQ, (i == 7) ? 8'h01 : 8'h03);
		end
		conv(28'sh0000123);
		chk({23'h000000, irq}, 24'h000000);
		rd(SDADC_OFS_IRQ, 8'h05);
		wr(SDADC_OFS_RES_LO, 8'hAA);
		wr(8'h07, 8'hFF);
		rd(SDADC_OFS_RES_LO, 8'h23);
		rd(8'h07, 8'h00);
		wr(SDADC_OFS_IRQ, 8'h03);
		wr(SDADC_OFS_CTRL1, 8'h24);
		conv(28'sh0000055);
		chk({23'h000000, irq}, 24'h000000);
		rd(SDADC_OFS_RES_LO, 8'h23);
		rd(SDADC_OFS_CTRL1, 8'h24);
		wr(SDADC_OFS_CTRL1, 8'h04);
		conv(28'sh0000066);
		rd(SDADC_OFS_RES_LO, 8'h66);
		chk({23'h000000, irq}, 24'h000001);
		wr(SDADC_OFS_CTRL1, 8'h00);
		// A tick launched on the powering-down edge still stands for one cycle.
		@(posedge clk);
		repeat (40) begin
			@(posedge clk);
			chk({22'h000000, fe_ctl.power, fe_ctl.mclk_tick}, 24'h000000);
		end
		rd(SDADC_OFS_RES_LO, 8'h66);
		repeat (2) @(posedge clk);
		results();
	end
endmodule
